// ---- src/decode_table.sv ----
// block decode table: one slave index per address block, registered read
`timescale 1ns/1ns
module decode_table
    import shared_bus_pkg::*;
#(
    parameter int unsigned ADDR_W     = ADDR_SPACE_DEFAULT,
    parameter int unsigned BLOCK_BITS = BLOCK_BITS_DEFAULT,
    parameter int unsigned NUM_SLAVES = NUM_SLAVES_DEFAULT,
    parameter logic [63:0] SLV_BASE [NUM_SLAVES] = '{64'h0, 64'h400},
    parameter logic [63:0] SLV_SIZE [NUM_SLAVES] = '{64'h400, 64'h3c00}
) (
    input  wire logic                        i_sys_clk,
    input  wire logic [ADDR_W-BLOCK_BITS-1:0] i_block,
    output logic                             o_hit,
    output logic [SLV_W-1:0]                 o_slave
);
    localparam int unsigned ENTRIES = 1 << (ADDR_W - BLOCK_BITS);
    logic [SLV_W:0] table_mem [ENTRIES];
    // build table: each block owned by at most one slave, first owner kept
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_entry
            function automatic logic [SLV_W:0] owner(input int unsigned blk);
                logic [63:0] a;
                owner = '0;
                a = 64'(blk) << BLOCK_BITS;
                for (int s = NUM_SLAVES - 1; s >= 0; s--) begin
                    if (SLV_SIZE[s] == 64'h0 || (a >= SLV_BASE[s] && // see R15
                        a < SLV_BASE[s] + SLV_SIZE[s])) begin
                        owner = {1'b1, SLV_W'(s)};
                    end
                end
            endfunction
            assign table_mem[g] = owner(g);
        end
    endgenerate
    // a regionless slave claims the whole space, so it cannot share it
    initial begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            if (SLV_SIZE[s] == 64'h0 && NUM_SLAVES > 1) $error("regionless slave overlaps"); // see R15
        end
    end
    always_ff @(posedge i_sys_clk) begin
        {o_hit, o_slave} <= table_mem[i_block];
    end
endmodule // decode_table

// ---- src/priority_shared_bus_decoder.sv ----
// fixed priority shared bus with block address decoder
// Contract
// R01: one to four upstream request ports
// R02: granted address, data, size passed unchanged
// R03: route by region, else no-memory reply
// R04: request evaluated same cycle, grant immediate
// R05: master waits for grant-ok before access
// R06: grant held while slave answers wait
// R07: fixed priority, port zero highest
// R08: at most one port granted
// R09: reads and writes both pass through
// R10: address space 8 to 64 bits
// R11: fixed blocks, each at most one slave
// R12: table entries equal space over block
// R13: block size not above smallest region
// R14: slave regions must not overlap
// R15: regionless slave covers all, overlap refused
// R16: region query reports configured base address
// R17: arbitration can be turned off
// R18: arbitration off forwards requests directly
// R19: size qualifier codes one to four
`timescale 1ns/1ns
module priority_shared_bus_decoder
    import shared_bus_pkg::*;
#(
    parameter int unsigned NUM_PORTS  = NUM_PORTS_MAX,
    parameter int unsigned ADDR_W     = ADDR_SPACE_DEFAULT,
    parameter int unsigned DATA_W     = DATA_W_DEFAULT,
    parameter int unsigned BLOCK_BITS = BLOCK_BITS_DEFAULT,
    parameter int unsigned NUM_SLAVES = NUM_SLAVES_DEFAULT,
    parameter logic [63:0] BASE_ADDR  = 64'h0,
    parameter bit          ARB_EN     = 1'b1,
    parameter logic [63:0] SLV_BASE [NUM_SLAVES] = '{64'h0, 64'h400},
    parameter logic [63:0] SLV_SIZE [NUM_SLAVES] = '{64'h400, 64'h3c00}
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_reset_n,
    input  wire logic [NUM_PORTS-1:0]        i_bus_request_call,
    input  wire logic [NUM_PORTS-1:0]        i_access_valid,
    input  wire logic [NUM_PORTS-1:0]        i_access_write,
    input  wire logic [NUM_PORTS*ADDR_W-1:0] i_access_addr,
    input  wire logic [NUM_PORTS*DATA_W-1:0] i_access_wdata,
    input  wire logic [NUM_PORTS*SIZE_W-1:0] i_access_size,
    input  wire logic                        i_slave_done,
    input  wire logic [STAT_W-1:0]           i_slave_status,
    input  wire logic [DATA_W-1:0]           i_slave_rdata,
    output logic [NUM_PORTS-1:0]             o_grant,
    output logic                             o_down_valid,
    output logic                             o_down_write,
    output logic [ADDR_W-1:0]                o_down_addr,
    output logic [DATA_W-1:0]                o_down_wdata,
    output logic [SIZE_W-1:0]                o_down_size,
    output logic [SLV_W-1:0]                 o_down_slave,
    output logic [NUM_PORTS-1:0]             o_reply_valid,
    output logic [STAT_W-1:0]                o_reply_status,
    output logic [DATA_W-1:0]                o_reply_rdata,
    output logic [63:0]                      o_region_start
);
    initial begin
        if (NUM_PORTS < 1 || NUM_PORTS > NUM_PORTS_MAX) $error("bad port count"); // see R01
        if (!(ADDR_W inside {8, 16, 24, 32, 36, 64})) $error("bad space"); // see R10
    end

    bus_state_t               state;
    logic [NUM_PORTS-1:0]     owner;
    logic [NUM_PORTS-1:0]     next_owner;
    logic [NUM_PORTS-1:0]     sel_req;
    logic                     hit;
    logic [SLV_W-1:0]         slave_idx;
    logic [ADDR_W-1:0]        sel_addr;
    logic                     sel_write;
    logic [DATA_W-1:0]        sel_wdata;
    logic [SIZE_W-1:0]        sel_size;
    logic                     sel_valid;
    logic                     pend;
    logic [ADDR_W-BLOCK_BITS-1:0] look_block;

    // requests seen this cycle; arbitration off forwards accesses directly
    assign sel_req = ARB_EN ? i_bus_request_call : i_access_valid; // see R17 R18

    // lowest index wins, one-hot result
    always_comb begin
        next_owner = '0;
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (sel_req[p]) begin
                next_owner = NUM_PORTS'(1) << p; // see R07 R08
            end
        end
    end

    // same-cycle grant, held while slave keeps answering wait
    always_comb begin
        o_grant = (state == ST_HOLD) ? owner : next_owner; // see R04 R06
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            owner <= NUM_PORTS'(GRANT_RESET);
        end else begin
            case (state)
                ST_IDLE: begin
                    if (sel_valid && |(next_owner & i_access_valid)) begin
                        state <= ST_HOLD;
                        owner <= next_owner;
                    end
                end
                ST_HOLD: begin
                    // unmapped access ends at once, nobody downstream will answer
                    if (pend && !hit) begin // see R03
                        state <= ST_IDLE;
                        owner <= NUM_PORTS'(GRANT_RESET);
                    end else if (i_slave_done && i_slave_status != wait_reply) begin // see R06
                        state <= ST_IDLE;
                        owner <= NUM_PORTS'(GRANT_RESET);
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    owner <= NUM_PORTS'(GRANT_RESET);
                end
            endcase
        end
    end

    // mux the granted port's access through unchanged
    always_comb begin
        sel_addr  = '0;
        sel_write = 1'b0;
        sel_wdata = '0;
        sel_size  = '0;
        sel_valid = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (o_grant[p] && i_access_valid[p]) begin // see R05
                sel_addr  = i_access_addr[p*ADDR_W +: ADDR_W]; // see R02
                sel_write = i_access_write[p]; // see R09
                sel_wdata = i_access_wdata[p*DATA_W +: DATA_W];
                sel_size  = i_access_size[p*SIZE_W +: SIZE_W]; // see R19
                sel_valid = 1'b1;
            end
        end
    end

    // decode the taken access again while it is held, so the slave index stays put
    assign look_block = (state == ST_IDLE) ? sel_addr[ADDR_W-1:BLOCK_BITS]
                                           : o_down_addr[ADDR_W-1:BLOCK_BITS];

    decode_table #(
        .ADDR_W     (ADDR_W),
        .BLOCK_BITS (BLOCK_BITS),
        .NUM_SLAVES (NUM_SLAVES),
        .SLV_BASE   (SLV_BASE),
        .SLV_SIZE   (SLV_SIZE)
    ) u_table (
        .i_sys_clk (i_sys_clk),
        .i_block   (look_block), // see R11 R12
        .o_hit     (hit),
        .o_slave   (slave_idx)
    );

    // registered downstream side; decode result lines up one cycle later
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend         <= 1'b0;
            o_down_write <= 1'b0;
            o_down_addr  <= '0;
            o_down_wdata <= '0;
            o_down_size  <= '0;
        end else begin
            pend         <= sel_valid && state == ST_IDLE;
            // access held still for the whole transfer, wait replies included
            if (sel_valid && state == ST_IDLE) begin // see R02
                o_down_write <= sel_write;
                o_down_addr  <= sel_addr;
                o_down_wdata <= sel_wdata;
                o_down_size  <= sel_size;
            end
        end
    end

    always_comb begin
        o_down_valid = (pend && hit) || (state == ST_HOLD && !pend); // see R03
        o_down_slave = slave_idx;
    end

    // reply path back to the owner
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reply_valid  <= '0;
            o_reply_status <= STATUS_RESET;
            o_reply_rdata  <= '0;
        end else if (pend && !hit) begin
            o_reply_valid  <= owner;
            o_reply_status <= no_memory_reply; // see R03
            o_reply_rdata  <= '0;
        end else if (state == ST_HOLD && i_slave_done) begin
            o_reply_valid  <= owner;
            o_reply_status <= i_slave_status;
            o_reply_rdata  <= i_slave_rdata;
        end else begin
            o_reply_valid  <= '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_region_start <= BASE_ADDR;
        end else begin
            o_region_start <= BASE_ADDR; // see R16
        end
    end

    onehot_grant_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R08
        $onehot0(o_grant)) else $error("more than one grant");
    prio_grant_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R07
        (state == ST_IDLE && sel_req[0]) |-> o_grant[0]) else $error("port 0 lost");
    hold_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R06
        (state == ST_HOLD && i_slave_done && i_slave_status == wait_reply)
        |=> (state == ST_HOLD && $stable(owner))) else $error("grant dropped");
    nomem_reply_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R03
        (pend && !hit) |=> (o_reply_status == no_memory_reply && |o_reply_valid
        && state == ST_IDLE)) else $error("no-memory missing");
    same_cycle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R04
        (state == ST_IDLE && |sel_req) |-> |o_grant) else $error("grant delayed");
    addr_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R02
        (state == ST_IDLE && sel_valid) |=> o_down_addr == $past(sel_addr))
        else $error("addr changed");
    write_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R09
        (state == ST_IDLE && sel_valid) |=> o_down_write == $past(sel_write))
        else $error("dir changed");
    down_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R02
        (state == ST_HOLD && !pend) |-> ($stable(o_down_addr) && $stable(o_down_slave)))
        else $error("access moved");
    region_base_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // see R16
        ##1 o_region_start == BASE_ADDR) else $error("bad base");

    cover_write_c: cover property (@(posedge i_sys_clk) sel_valid && sel_write);
    cover_nomem_c: cover property (@(posedge i_sys_clk) pend && !hit);
    cover_wait_c:  cover property (@(posedge i_sys_clk)
        state == ST_HOLD && i_slave_done && i_slave_status == wait_reply);
    cover_contend_c: cover property (@(posedge i_sys_clk) $countones(sel_req) > 1);
endmodule // priority_shared_bus_decoder

// ---- src/shared_bus_pkg.sv ----
// constants and types for the priority shared bus decoder
package shared_bus_pkg;
    localparam int unsigned NUM_PORTS_MAX      = 4;
    localparam int unsigned ADDR_SPACE_DEFAULT = 16;
    localparam int unsigned BLOCK_BITS_DEFAULT = 10;
    localparam int unsigned NUM_SLAVES_DEFAULT = 2;
    localparam int unsigned DATA_W_DEFAULT     = 32;
    localparam int unsigned SIZE_W             = 3;
    localparam int unsigned STAT_W             = 3;
    localparam int unsigned SLV_W              = 3;
    // access size qualifier codes
    localparam logic [2:0] SIZE_8              = 3'h1;
    localparam logic [2:0] SIZE_16             = 3'h2;
    localparam logic [2:0] SIZE_32             = 3'h3;
    localparam logic [2:0] SIZE_64             = 3'h4;
    // reply status codes
    localparam logic [2:0] ok_reply            = 3'h0;
    localparam logic [2:0] wait_reply          = 3'h1;
    localparam logic [2:0] error_reply         = 3'h2;
    localparam logic [2:0] no_memory_reply     = 3'h3;
    localparam logic [2:0] grant_ok_code       = 3'h4;
    localparam logic [3:0] GRANT_RESET        = 4'h0;
    localparam logic [2:0] STATUS_RESET       = 3'h0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD
    } bus_state_t;
endpackage

// ---- verif/bus_slave_model.sv ----
// slave side model: answers accesses after a chosen number of wait replies
`timescale 1ns/1ns
module bus_slave_model
    import shared_bus_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_down_valid,
    input  wire logic [15:0] i_down_addr,
    input  wire logic [3:0]  i_waits,
    input  wire logic        i_err,
    output logic             o_done,
    output logic [2:0]       o_status,
    output logic [31:0]      o_rdata
);
    logic       busy;
    logic       fin;
    logic [3:0] cnt;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy <= 1'b0;
            fin <= 1'b0;
            cnt <= 4'h0;
            o_done <= 1'b0;
            o_status <= wait_reply;
            o_rdata <= 32'h0;
        end else begin
            o_done <= 1'b0;
            o_rdata <= ~o_rdata;
            // only addresses below 0x4000 have a slave behind them
            if (!busy && i_down_valid && i_down_addr < 16'h4000) begin
                busy <= 1'b1;
                cnt <= i_waits;
            end else if (busy && !fin) begin
                o_done <= 1'b1;
                if (cnt != 4'h0) begin
                    o_status <= wait_reply;
                    cnt <= cnt - 4'h1;
                end else begin
                    o_status <= i_err ? error_reply : ok_reply;
                    o_rdata <= {16'h5a5a, i_down_addr};
                    fin <= 1'b1;
                end
            end else if (fin && !i_down_valid) begin
                busy <= 1'b0;
                fin <= 1'b0;
            end
        end
    end
endmodule // bus_slave_model

// ---- verif/tb_priority_shared_bus_decoder.sv ----
// random and corner tests for the priority shared bus decoder
`timescale 1ns/1ns
module tb_priority_shared_bus_decoder;
    import shared_bus_pkg::*;
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, err = 1'b0, i_slave_done;
    logic [3:0] i_bus_request_call = '0, i_access_valid = '0, i_access_write = '0;
    logic [3:0] waits = '0, o_grant, o_reply_valid, direct_grant;
    logic [3:0] masks [6] = '{4'hf, 4'he, 4'hc, 4'h8, 4'ha, 4'h6};
    logic [15:0] corner_addr [5] = '{16'h03ff, 16'h0400, 16'h3fff, 16'h4000, 16'hffff};
    logic [63:0] i_access_addr = '0, o_region_start;
    logic [127:0] i_access_wdata = '0;
    logic [11:0] i_access_size = '0;
    logic [2:0] i_slave_status, o_down_size, o_down_slave, o_reply_status;
    logic [31:0] i_slave_rdata, o_down_wdata, o_reply_rdata, rnd = 32'h00010b05;
    logic [15:0] o_down_addr;
    logic o_down_valid, o_down_write;
    int fails = 0, checks = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    priority_shared_bus_decoder #(.BASE_ADDR(64'h4000), .BLOCK_BITS(10)) i_dut (
        .i_sys_clk, .i_reset_n,
        .i_bus_request_call, .i_access_valid, .i_access_write, .i_access_addr,
        .i_access_wdata, .i_access_size, .i_slave_done, .i_slave_status, .i_slave_rdata,
        .o_grant, .o_down_valid, .o_down_write, .o_down_addr, .o_down_wdata, .o_down_size,
        .o_down_slave, .o_reply_valid, .o_reply_status, .o_reply_rdata, .o_region_start);
    bus_slave_model i_slave (.i_sys_clk, .i_reset_n, .i_down_valid(o_down_valid),
        .i_down_addr(o_down_addr), .i_waits(waits), .i_err(err), .o_done(i_slave_done),
        .o_status(i_slave_status), .o_rdata(i_slave_rdata));
    // same traffic with arbitration off: an access alone earns the grant
    priority_shared_bus_decoder #(.ARB_EN(1'b0)) i_dut_direct (.i_sys_clk, .i_reset_n,
        .i_bus_request_call, .i_access_valid, .i_access_write, .i_access_addr,
        .i_access_wdata, .i_access_size, .i_slave_done, .i_slave_status, .i_slave_rdata,
        .o_grant(direct_grant), .o_down_valid(), .o_down_write(), .o_down_addr(),
        .o_down_wdata(), .o_down_size(), .o_down_slave(), .o_reply_valid(),
        .o_reply_status(), .o_reply_rdata(), .o_region_start());
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic acc(input int p, input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic [2:0] s);
        int n;
        logic [2:0] est;
        est = (a >= 16'h4000) ? no_memory_reply : (err ? error_reply : ok_reply);
        @(posedge i_sys_clk);
        i_bus_request_call[p] <= 1'b1;
        i_access_valid[p] <= 1'b1;
        i_access_write[p] <= w;
        i_access_addr[p*16 +: 16] <= a;
        i_access_wdata[p*32 +: 32] <= d;
        i_access_size[p*3 +: 3] <= s;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_grant[p] !== 1'b1 && n < 60);
        chk("direct_grant", 4'h1 << p, direct_grant);
        @(posedge i_sys_clk);
        i_bus_request_call[p] <= 1'b0;
        i_access_valid[p] <= 1'b0;
        @(negedge i_sys_clk);
        if (est != no_memory_reply) begin
            chk("down_valid", 1, o_down_valid);
            chk("down_addr", a, o_down_addr);
            chk("down_write", w, o_down_write);
            chk("down_size", s, o_down_size);
            chk("down_slave", a >= 16'h0400, o_down_slave);
            if (w) chk("down_wdata", d, o_down_wdata);
        end else begin
            chk("down_valid", 1'b0, o_down_valid);
        end
        n = 0;
        while (!(o_reply_valid[p] === 1'b1 && o_reply_status !== wait_reply) && n < 60) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("reply_valid", 4'h1 << p, o_reply_valid);
        chk("reply_status", est, o_reply_status);
        if (!w && est == ok_reply) chk("reply_rdata", {16'h5a5a, a}, o_reply_rdata);
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(negedge i_sys_clk);
        chk("region_start", 64'h4000, o_region_start);
        foreach (masks[k]) begin
            @(posedge i_sys_clk);
            i_bus_request_call <= masks[k];
            @(negedge i_sys_clk);
            chk("grant", masks[k] & (~masks[k] + 4'h1), o_grant);
            chk("direct_grant", 4'h0, direct_grant);
        end
        @(posedge i_sys_clk);
        i_bus_request_call <= '0;
        foreach (corner_addr[k])
            acc(k % 4, 1'b0, corner_addr[k], 32'h0, SIZE_8 + k % 4);
        waits = 4'h3;
        fork
            acc(1, 1'b1, 16'h0123, 32'hcafe0001, SIZE_32);
            begin
                repeat (4) @(posedge i_sys_clk);
                i_bus_request_call[0] <= 1'b1;
                @(negedge i_sys_clk);
                chk("grant_hold", 4'h2, o_grant);
                @(posedge i_sys_clk);
                i_bus_request_call[0] <= 1'b0;
            end
        join
        repeat (50) begin
            rnd = nxt(rnd);
            err = rnd[7] & rnd[8];
            waits = {1'b0, rnd[11:9]};
            acc(rnd[1:0], rnd[2], rnd[31:16] & (rnd[4] ? 16'hffff : 16'h3fff),
                {rnd[15:0], rnd[31:16]}, {1'b0, rnd[6:5]} + 3'h1);
        end
        wrap_up();
    end
endmodule // tb_priority_shared_bus_decoder
